// file: src/sbm_multiplier.sv
// Top of the single-cycle byte multiplier with its product register pair.
`timescale 1ns/1ps
// Contract
// - Multiply completes within one instruction cycle.
// - Unsigned operands give full 16-bit product.
// - High byte and low byte to product pair.
// - Multiply leaves all ALU status flags unchanged.
// - Operands from working register and file register.
module sbm_multiplier
    import sbm_pkg::*;
#(
    parameter int unsigned OPW = SBM_OPERAND_W
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire sbm_request_t req,
    input  wire logic [7:0]   status_in,
    input  wire logic         status_we,
    output sbm_product_t      product,
    output logic [7:0]        status_out,
    output logic [7:0]        working_out,
    output logic [7:0]        file_out
);
    logic [SBM_PRODUCT_W-1:0] prod_q;
    logic [SBM_PRODUCT_W-1:0] prod_d;
    logic [SBM_PRODUCT_W-1:0] mul_result;
    logic [7:0]               status_q;
    logic [7:0]               status_d;

    // The multiplier reads the working register and file operand.
    sbm_array_mul #(
        .W (OPW)
    ) u_mul (
        .a (req.working_register),
        .b (req.file_operand),
        .p (mul_result)
    );

    // The full product loads as one word in the multiply cycle.
    always_comb begin
        prod_d = prod_q;
        if (req.start) begin
            prod_d = mul_result;
        end
    end

    // Status changes only by its own write, never by a multiply.
    always_comb begin
        status_d = status_q;
        if (status_we) begin
            status_d = status_in;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prod_q   <= SBM_PRODUCT_RST;
            status_q <= SBM_STATUS_RST;
        end else begin
            prod_q   <= prod_d;
            status_q <= status_d;
        end
    end

    // Picks one byte of the product word at the given bit position.
    function automatic logic [7:0] sbm_byte_of(
        input logic [SBM_PRODUCT_W-1:0] word,
        input int unsigned              lsb
    );
        return word[lsb +: 8];
    endfunction

    // The upper byte feeds the high register, the lower the low one.
    assign product.product_high_byte = sbm_byte_of(prod_q, SBM_HIGH_LSB);
    assign product.product_low_byte  = sbm_byte_of(prod_q, SBM_LOW_LSB);
    assign status_out  = status_q;
    // Operands pass back unchanged so their registers are not modified.
    assign working_out = req.working_register;
    assign file_out    = req.file_operand;

    chk_product_value: assert property (@(posedge clk) disable iff (!nrst)
        req.start |=> prod_q ==
            16'(16'($past(req.working_register)) *
                16'($past(req.file_operand))))
        else $error("product wrong after multiply");

    chk_product_hold: assert property (@(posedge clk) disable iff (!nrst)
        !req.start |=> $stable(prod_q))
        else $error("product changed without multiply");

    chk_high_byte: assert property (@(posedge clk) disable iff (!nrst)
        req.start |=> product.product_high_byte ==
            8'((16'($past(req.working_register)) *
                16'($past(req.file_operand))) >> 8))
        else $error("high byte wrong");

    chk_low_byte: assert property (@(posedge clk) disable iff (!nrst)
        req.start |=> product.product_low_byte ==
            8'(16'($past(req.working_register)) *
               16'($past(req.file_operand))))
        else $error("low byte wrong");

    chk_full_width: assert property (@(posedge clk) disable iff (!nrst)
        (req.start && req.working_register == 8'hff &&
         req.file_operand == 8'hff) |=> prod_q == 16'hfe01)
        else $error("product truncated");

    chk_zero_operand: assert property (@(posedge clk) disable iff (!nrst)
        (req.start && (req.working_register == 8'h00 ||
                       req.file_operand == 8'h00)) |=> prod_q == 16'h0000)
        else $error("zero operand gave nonzero product");

    chk_unit_file: assert property (@(posedge clk) disable iff (!nrst)
        (req.start && req.file_operand == 8'h01) |=>
            prod_q == {8'h00, $past(req.working_register)})
        else $error("unit file operand wrong");

    chk_unit_working: assert property (@(posedge clk) disable iff (!nrst)
        (req.start && req.working_register == 8'h01) |=>
            prod_q == {8'h00, $past(req.file_operand)})
        else $error("unit working operand wrong");

    chk_msb_operand: assert property (@(posedge clk) disable iff (!nrst)
        (req.start && req.file_operand == 8'h80) |=>
            prod_q == (16'($past(req.working_register)) << 7))
        else $error("msb operand treated as signed");

    chk_high_bound: assert property (@(posedge clk) disable iff (!nrst)
        req.start |=> product.product_high_byte <= 8'hfe)
        else $error("high byte beyond unsigned range");

    chk_back_to_back: assert property (@(posedge clk) disable iff (!nrst)
        (req.start ##1 req.start) |=> prod_q ==
            16'(16'($past(req.working_register)) *
                16'($past(req.file_operand))))
        else $error("second multiply in a row wrong");

    chk_pair_together: assert property (@(posedge clk) disable iff (!nrst)
        req.start |=>
            {product.product_high_byte, product.product_low_byte} ==
            16'(16'($past(req.working_register)) *
                16'($past(req.file_operand))))
        else $error("product bytes out of step");

    chk_flags_kept: assert property (@(posedge clk) disable iff (!nrst)
        (req.start && !status_we) |=> $stable(status_q))
        else $error("multiply touched status");

    chk_status_write: assert property (@(posedge clk) disable iff (!nrst)
        status_we |=> status_out == $past(status_in))
        else $error("status write lost");

    chk_status_stable: assert property (@(posedge clk) disable iff (!nrst)
        !status_we |=> $stable(status_out))
        else $error("status changed without write");

    chk_operands_kept: assert property (@(posedge clk) disable iff (!nrst)
        working_out == req.working_register && file_out == req.file_operand)
        else $error("operand modified");

    chk_operands_after: assert property (@(posedge clk) disable iff (!nrst)
        req.start |-> working_out == req.working_register)
        else $error("working operand altered by multiply");

    chk_reset_product: assert property (@(posedge clk)
        !nrst |-> prod_q == SBM_PRODUCT_RST)
        else $error("product not cleared in reset");

    chk_reset_status: assert property (@(posedge clk)
        !nrst |-> status_q == SBM_STATUS_RST)
        else $error("status not cleared in reset");
endmodule // sbm_multiplier

// file: src/sbm_pkg.sv
// Package of types and constants for the single-cycle byte multiplier.
package sbm_pkg;
    localparam int unsigned SBM_OPERAND_W = 8;
    localparam int unsigned SBM_PRODUCT_W = 16;
    localparam logic [15:0] SBM_PRODUCT_RST = 16'h0000;
    localparam logic [7:0]  SBM_STATUS_RST  = 8'h00;
    localparam int unsigned SBM_HIGH_LSB = 8;
    localparam int unsigned SBM_LOW_LSB  = 0;

    typedef struct packed {
        logic       start;
        logic [7:0] working_register;
        logic [7:0] file_operand;
    } sbm_request_t;

    typedef struct packed {
        logic [7:0] product_high_byte;
        logic [7:0] product_low_byte;
    } sbm_product_t;
endpackage

// file: src/sbm_array_mul.sv
// Combinational unsigned array multiplier built from shifted partial products.
`timescale 1ns/1ps
module sbm_array_mul #(
    parameter int unsigned W = 8
) (
    input  wire logic [W-1:0]   a,
    input  wire logic [W-1:0]   b,
    output logic      [2*W-1:0] p
);
    logic [2*W-1:0] part [W];

    // Each partial product is one operand gated by one bit of the other.
    for (genvar i = 0; i < W; i++) begin : g_part
        assign part[i] = b[i] ? ({{W{1'b0}}, a} << i) : '0;
    end

    // Partial products sum at full width so no bit is lost.
    always_comb begin
        p = '0;
        for (int i = 0; i < W; i++) begin
            p = p + part[i];
        end
    end
endmodule // sbm_array_mul

// file: test/sbm_core_model.sv
// Core model that issues multiply requests to the multiplier.
`timescale 1ns/1ps
module sbm_core_model
    import sbm_pkg::*;
(
    input  wire logic   clk,
    output sbm_request_t req
);
    initial req = '0;
    task automatic mul(input logic [7:0] w, input logic [7:0] f);
        @(posedge clk) #1 req = '{1'b1, w, f};
        @(posedge clk) #1 req = '{1'b0, ~w, ~f};
    endtask
    task automatic mul_pair(input logic [7:0] w0, f0, w1, f1);
        @(posedge clk) #1 req = '{1'b1, w0, f0};
        @(posedge clk) #1 req = '{1'b1, w1, f1};
        @(posedge clk) #1 req = '{1'b0, ~w1, ~f1};
    endtask
endmodule // sbm_core_model

// file: test/tb_single_cycle_byte_multiplier.sv
// Self-checking testbench for the byte multiplier.
`timescale 1ns/1ps
module tb_single_cycle_byte_multiplier
    import sbm_pkg::*;
;
    logic         clk = 0, nrst = 0, status_we = 0;
    logic [7:0]   status_in = 8'h00, st, wo, fo;
    sbm_request_t req;
    sbm_product_t prod;
    int           failures = 0, num_checks = 0;
    sbm_core_model m (.clk(clk), .req(req));
    sbm_multiplier i_dut (.clk(clk), .nrst(nrst), .req(req),
        .status_in(status_in), .status_we(status_we), .product(prod),
        .status_out(st), .working_out(wo), .file_out(fo));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_plain();
        logic [7:0] v [5] = '{8'h00, 8'hff, 8'h12, 8'h80, 8'h34};
        for (int i = 0; i < 5; i++)
            for (int j = 0; j < 5; j++) begin
                m.mul(v[i], v[j]);
                chk({16'h0, prod}, {24'h0, v[i]} * v[j]);
                chk({24'h0, wo}, {24'h0, ~v[i]});
                chk({24'h0, fo}, {24'h0, ~v[j]});
            end
    endtask
    task automatic mul16(input logic [15:0] a, input logic [15:0] b,
                         output logic [31:0] r);
        r = '0;
        for (int i = 0; i < 4; i++) begin
            m.mul(a[8*(i/2)+:8], b[8*(i%2)+:8]);
            r += {16'h0, prod} << (8 * (i / 2 + i % 2));
        end
    endtask
    task automatic t_status();
        @(posedge clk) #1 status_in = 8'ha5;
        status_we = 1;
        @(posedge clk) #1 status_we = 0;
        chk({24'h0, st}, 32'h0000_00a5);
        m.mul(8'hff, 8'hff);
        chk({24'h0, st}, 32'h0000_00a5);
        chk({16'h0, prod}, 32'h0000_fe01);
    endtask
    task automatic t_back();
        m.mul_pair(8'h12, 8'h34, 8'hff, 8'h02);
        chk({16'h0, prod}, 32'h0000_01fe);
        repeat (3) @(posedge clk);
        #1 chk({16'h0, prod}, 32'h0000_01fe);
    endtask
    task automatic t_reset();
        @(posedge clk) #1 nrst = 0;
        #1 chk({16'h0, prod}, 32'h0);
        chk({24'h0, st}, 32'h0);
        repeat (3) @(posedge clk);
        #1 nrst = 1;
        m.mul(8'h12, 8'h34);
        chk({16'h0, prod}, 32'h0000_03a8);
        chk({24'h0, st}, 32'h0);
    endtask
    task automatic t_signed(input logic [7:0] w, input logic [7:0] f);
        logic [15:0] p;
        m.mul(w, f);
        p = prod;
        if (w[7]) p[15:8] -= f;
        if (f[7]) p[15:8] -= w;
        chk({16'h0, p}, {16'h0, 16'({{8{w[7]}}, w} * {{8{f[7]}}, f})});
    endtask
    task automatic t_wide(input logic [15:0] a, input logic [15:0] b);
        logic [31:0] r;
        mul16(a, b, r);
        chk(r, {16'h0, a} * b);
    endtask
    task automatic t_swide(input logic [15:0] a, input logic [15:0] b);
        logic [31:0] r;
        mul16(a, b, r);
        if (b[15]) r[31:16] -= a;
        if (a[15]) r[31:16] -= b;
        chk(r, {{16{a[15]}}, a} * {{16{b[15]}}, b});
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1 nrst = 1;
        t_status();
        t_plain();
        t_signed(8'h80, 8'hff);
        t_signed(8'h7f, 8'h81);
        t_back();
        t_wide(16'hfedc, 16'h1234);
        t_swide(16'hfedc, 16'h1234);
        t_swide(16'h8001, 16'hff00);
        t_reset();
        finish_test();
    end
    initial begin
        #20000;
        failures++;
        finish_test();
    end
endmodule // tb_single_cycle_byte_multiplier
